// [hw/nand_port_defs.vh]
// Constants for the NAND command/address port controller
`ifndef NAND_PORT_DEFS_VH
`define NAND_PORT_DEFS_VH
`define CLK_PERIOD_NS 10
// Bus timing figures in ns, converted to cycles (least times round up)
`define T_SETUP_NS 10
`define T_SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_PULSE_NS 12
`define T_PULSE_CYC ((`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_HIGH_NS 10
`define T_HIGH_CYC ((`T_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// data_access_delay: data valid after output strobe fall
`define DATA_ACCESS_DELAY_NS 20
`define DATA_ACCESS_DELAY_CYC ((`DATA_ACCESS_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// WE high to busy, before ready/busy may be trusted
`define T_WB_NS 100
`define T_WB_CYC ((`T_WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Busy timeout, from longest busy (block erase 10 ms)
`define T_BUSY_MAX_US 10000
`define T_BUSY_MAX_CYC (`T_BUSY_MAX_US * 1000 / `CLK_PERIOD_NS)
// Cache busy limits
`define CACHE_BUSY_SHORT_US 1
`define CACHE_BUSY_LONG_US 2400
// Address layout
`define COL_BITS 14
`define ROW_BITS 21
`define COL_HI_MASK 8'h3f
`define ROW_HI_MASK 8'h1f
`define PAGE_LSB 0
`define PAGE_MSB 7
`define BLOCK_LSB 8
`define BLOCK_MSB 20
// Opcodes for user requests
`define OP_CMD 2'h0
`define OP_ADDR 2'h1
`define OP_WRITE 2'h2
`define OP_READ 2'h3
`define FIFO_W 8
`define FIFO_D 8
`define FIFO_AW 3
`endif

// [hw/nand_port_ctrl.v]
// NAND command/address port controller with read-data FIFO
`timescale 1ns/10ps
`include "nand_port_defs.vh"

module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk, // Clock
  input wire rstn, // Synchronous reset, active low
  input wire [WIDTH-1:0] in_data, // Write data
  input wire in_valid, // Write request
  output wire in_ready, // Space available
  output wire [WIDTH-1:0] out_data, // Read data
  output wire out_valid, // Data available
  input wire out_ready // Consumer takes data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ff;
  reg [AW:0] rd_ff;
  wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire empty = (wr_ff == rd_ff);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ff[AW-1:0]];
  always @(posedge mclk)
  begin
    if (push)
      mem[wr_ff[AW-1:0]] <= in_data;
    if (!rstn)
    begin
      wr_ff <= {(AW+1){1'b0}};
      rd_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
        rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule // byte_fifo

module nand_port_ctrl (
  input wire mclk, // 100 MHz clock
  input wire rstn, // Synchronous reset, active low
  input wire req_valid, // User request present
  output reg req_ready_ff, // Request taken at the previous edge (one-cycle pulse)
  input wire [1:0] req_op, // Command, address, write, read
  input wire [7:0] req_data, // Command or data byte
  input wire req_die, // Target die 0 or 1
  input wire req_last, // Release select after this request
  input wire req_wait, // Wait ready/busy after this request, except a read
  input wire [`COL_BITS-1:0] req_col, // Column for address op
  input wire [`ROW_BITS-1:0] req_row, // Row for address op
  input wire wr_guard, // Allow program/erase when high
  output reg [7:0] rd_data_ff, // Read byte, registered after FIFO
  output reg rd_valid_ff, // Read byte available
  input wire rd_ready, // User takes read byte
  output reg busy_ff, // Controller sequence active
  output reg timeout_ff, // Busy wait expired (sticky until next request)
  output reg [12:0] blk_ff, // Block of last address
  output reg [7:0] page_ff, // Page of last address
  output reg cmd_latch_ff, // Command latch strobe
  output reg addr_latch_ff, // Address latch strobe
  output reg input_strobe_n_ff, // Write strobe, active low
  output reg output_strobe_n_ff, // Read strobe, active low
  output reg [1:0] sel_n_ff, // Per-die select, active low
  output reg write_guard_n_ff, // Write guard, low protects
  input wire [7:0] io_in, // Bus input
  output reg [7:0] io_out_ff, // Bus output
  output reg io_oe_ff, // Bus output enable
  input wire [1:0] idle_flag_open_drain // Ready/busy per die, pulled up
);
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_PULSE = 3'h2;
  localparam S_HIGH = 3'h3;
  localparam S_RLOW = 3'h4;
  localparam S_RHIGH = 3'h5;
  localparam S_WB = 3'h6;
  localparam S_BUSY = 3'h7;
  localparam integer BUSY_I = `T_BUSY_MAX_CYC;
  localparam integer WB_I = `T_WB_CYC;
  localparam integer SETUP_I = `T_SETUP_CYC;
  localparam integer PULSE_I = `T_PULSE_CYC;
  localparam integer HIGH_I = `T_HIGH_CYC;
  localparam integer ACC_I = `DATA_ACCESS_DELAY_CYC;
  localparam [23:0] BUSY_MAX = BUSY_I[23:0];
  localparam [7:0] WB_CYC = WB_I[7:0];
  localparam [3:0] SETUP_CYC = SETUP_I[3:0];
  localparam [3:0] PULSE_CYC = PULSE_I[3:0];
  localparam [3:0] HIGH_CYC = HIGH_I[3:0];
  localparam [3:0] ACC_CYC = ACC_I[3:0];

  reg [2:0] st_ff;
  reg [3:0] cnt_ff;
  reg [23:0] tmo_ff;
  reg [2:0] acyc_ff;
  reg [1:0] op_ff;
  reg die_ff;
  reg last_ff;
  reg wait_ff;
  reg [39:0] addr_sh_ff;
  reg fifo_push_ff;
  reg [7:0] fifo_in_ff;
  wire fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_pop = !rd_valid_ff || rd_ready;

  byte_fifo #(.WIDTH(`FIFO_W), .DEPTH(`FIFO_D), .AW(`FIFO_AW)) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_data(fifo_in_ff),
    .in_valid(fifo_push_ff),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  // Output stage, refilled when empty or when the user takes its byte
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end
    else if (fifo_pop)
    begin
      rd_valid_ff <= fifo_out_valid;
      rd_data_ff <= fifo_out_data;
    end
  end

  // Five address cycles packed low byte first
  wire [39:0] addr_bytes = {3'h0, req_row[20:16], req_row[15:8], req_row[7:0],
                            2'h0, req_col[13:8], req_col[7:0]};
  // A read needs room for its byte, including one in flight
  wire can_read = fifo_in_ready && !fifo_push_ff;
  wire die_ready = idle_flag_open_drain[die_ff];

  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      tmo_ff <= 24'h0;
      acyc_ff <= 3'h0;
      op_ff <= 2'h0;
      die_ff <= 1'b0;
      last_ff <= 1'b0;
      wait_ff <= 1'b0;
      addr_sh_ff <= 40'h0;
      fifo_push_ff <= 1'b0;
      fifo_in_ff <= 8'h00;
      req_ready_ff <= 1'b0;
      busy_ff <= 1'b0;
      timeout_ff <= 1'b0;
      blk_ff <= 13'h0000;
      page_ff <= 8'h00;
      cmd_latch_ff <= 1'b0;
      addr_latch_ff <= 1'b0;
      input_strobe_n_ff <= 1'b1;
      output_strobe_n_ff <= 1'b1;
      sel_n_ff <= 2'h3;
      write_guard_n_ff <= 1'b0;
      io_out_ff <= 8'h00;
      io_oe_ff <= 1'b0;
    end
    else
    begin
      req_ready_ff <= 1'b0;
      fifo_push_ff <= 1'b0;
      write_guard_n_ff <= wr_guard;
      case (st_ff)
        S_IDLE:
        begin
          busy_ff <= 1'b0;
          if (req_valid && !req_ready_ff && (req_op != `OP_READ || can_read))
          begin
            req_ready_ff <= 1'b1;
            busy_ff <= 1'b1;
            timeout_ff <= 1'b0;
            op_ff <= req_op;
            die_ff <= req_die;
            last_ff <= req_last;
            wait_ff <= req_wait;
            sel_n_ff <= req_die ? 2'h1 : 2'h2;
            cnt_ff <= 4'h0;
            if (req_op == `OP_ADDR)
            begin
              addr_sh_ff <= addr_bytes;
              acyc_ff <= 3'h4;
              io_out_ff <= addr_bytes[7:0];
              blk_ff <= req_row[`BLOCK_MSB:`BLOCK_LSB];
              page_ff <= req_row[`PAGE_MSB:`PAGE_LSB];
            end
            else
            begin
              acyc_ff <= 3'h0;
              io_out_ff <= req_data;
            end
            cmd_latch_ff <= (req_op == `OP_CMD);
            addr_latch_ff <= (req_op == `OP_ADDR);
            io_oe_ff <= (req_op != `OP_READ);
            st_ff <= (req_op == `OP_READ) ? S_RLOW : S_SETUP;
            if (req_op == `OP_READ)
              output_strobe_n_ff <= 1'b0;
          end
        end
        S_SETUP:
        begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff + 4'h1 >= SETUP_CYC)
          begin
            input_strobe_n_ff <= 1'b0;
            cnt_ff <= 4'h0;
            st_ff <= S_PULSE;
          end
        end
        S_PULSE:
        begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff + 4'h1 >= PULSE_CYC)
          begin
            input_strobe_n_ff <= 1'b1;
            cnt_ff <= 4'h0;
            st_ff <= S_HIGH;
          end
        end
        S_HIGH:
        begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff + 4'h1 >= HIGH_CYC)
          begin
            cnt_ff <= 4'h0;
            if (acyc_ff != 3'h0)
            begin
              acyc_ff <= acyc_ff - 3'h1;
              addr_sh_ff <= {8'h00, addr_sh_ff[39:8]};
              io_out_ff <= addr_sh_ff[15:8];
              st_ff <= S_SETUP;
            end
            else
            begin
              cmd_latch_ff <= 1'b0;
              addr_latch_ff <= 1'b0;
              io_oe_ff <= 1'b0;
              st_ff <= wait_ff ? S_WB : S_IDLE;
              if (!wait_ff && last_ff)
                sel_n_ff <= 2'h3;
            end
          end
        end
        S_RLOW:
        begin
          // Sample after access delay, then raise strobe long enough to release bus
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff + 4'h1 >= ACC_CYC)
          begin
            fifo_in_ff <= io_in;
            fifo_push_ff <= 1'b1;
            output_strobe_n_ff <= 1'b1;
            cnt_ff <= 4'h0;
            st_ff <= S_RHIGH;
          end
        end
        S_RHIGH:
        begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff + 4'h1 >= HIGH_CYC)
          begin
            cnt_ff <= 4'h0;
            st_ff <= S_IDLE;
            if (last_ff)
              sel_n_ff <= 2'h3;
          end
        end
        S_WB:
        begin
          // Ready/busy is not valid until the die has had time to go busy
          tmo_ff <= tmo_ff + 24'h1;
          if (tmo_ff + 24'h1 >= {16'h0, WB_CYC})
          begin
            tmo_ff <= 24'h0;
            st_ff <= S_BUSY;
          end
        end
        S_BUSY:
        begin
          tmo_ff <= tmo_ff + 24'h1;
          if (die_ready || tmo_ff + 24'h1 >= BUSY_MAX)
          begin
            timeout_ff <= !die_ready;
            tmo_ff <= 24'h0;
            st_ff <= S_IDLE;
            if (last_ff)
              sel_n_ff <= 2'h3;
          end
        end
        default:
          st_ff <= S_IDLE;
      endcase
    end
  end
endmodule // nand_port_ctrl

// [tb/nand_port_ctrl_asserts.sv]
// Port-level checker for the NAND port controller
`timescale 1ns/10ps
module nand_port_chk (
  input wire mclk, // Clock
  input wire rstn, // Reset, active low
  input wire wr_guard, // User guard request
  input wire write_guard_n_ff, // Guard pin
  input wire cmd_latch_ff, // Command latch
  input wire addr_latch_ff, // Address latch
  input wire input_strobe_n_ff, // Write strobe
  input wire output_strobe_n_ff, // Read strobe
  input wire [1:0] sel_n_ff, // Die selects
  input wire io_oe_ff // Bus drive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_one_die; sel_n_ff != 2'b00; endproperty
  a_one_die: assert property (p_one_die) else $error("both dies selected");
  property p_latch_excl; !(cmd_latch_ff && addr_latch_ff); endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
  property p_guard; $past(rstn) |-> write_guard_n_ff == $past(wr_guard); endproperty
  a_guard: assert property (p_guard) else $error("guard pin wrong");
  property p_we_len; $fell(input_strobe_n_ff) |=> !input_strobe_n_ff; endproperty
  a_we_len: assert property (p_we_len) else $error("write pulse short");
  property p_we_qual; !input_strobe_n_ff |-> io_oe_ff && sel_n_ff != 2'b11; endproperty
  a_we_qual: assert property (p_we_qual) else $error("write strobe unqualified");
  property p_re_qual;
    !output_strobe_n_ff |-> !io_oe_ff && !cmd_latch_ff && !addr_latch_ff && sel_n_ff != 2'b11;
  endproperty
  a_re_qual: assert property (p_re_qual) else $error("read strobe unqualified");
  property p_latch_hold; $fell(cmd_latch_ff) |-> input_strobe_n_ff && $past(input_strobe_n_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch dropped early");
  property p_sel_hold; $rose(input_strobe_n_ff) |-> $stable(sel_n_ff); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved at strobe");
  c_cmd: cover property ($fell(input_strobe_n_ff) && cmd_latch_ff);
  c_addr: cover property ($fell(input_strobe_n_ff) && addr_latch_ff);
  c_read: cover property ($fell(output_strobe_n_ff));
endmodule // nand_port_chk
bind nand_port_ctrl nand_port_chk u_chk (.mclk(mclk), .rstn(rstn), .wr_guard(wr_guard),
  .write_guard_n_ff(write_guard_n_ff), .cmd_latch_ff(cmd_latch_ff),
  .addr_latch_ff(addr_latch_ff), .input_strobe_n_ff(input_strobe_n_ff),
  .output_strobe_n_ff(output_strobe_n_ff), .sel_n_ff(sel_n_ff), .io_oe_ff(io_oe_ff));

// [tb/nand_die_model.sv]
// Two-die flash model for the port controller bench
`timescale 1ns/10ps
module nand_die_model (
  input wire mclk, // Busy timing clock
  input wire cle, // Command latch
  input wire ale, // Address latch
  input wire we_n, // Write strobe
  input wire rd_strb_n, // Read strobe
  input wire [1:0] ce_n, // Die selects
  input wire wp_n, // Write guard
  input wire [7:0] bus_o, // Controller drive
  input wire bus_oe, // Controller drives
  output wire [7:0] io_in, // Resolved bus
  output wire [1:0] rb // Ready/busy, pulled up
);
  reg [7:0] cmd, dout;
  reg [13:0] col;
  reg [20:0] row;
  reg [2:0] acnt;
  reg drv;
  integer bsy0, bsy1, prog_cnt;
  wire d = ce_n[0];
  wire act = ce_n != 2'b11;
  initial
  begin
    cmd = 8'h00;
    dout = 8'h00;
    col = 14'h0000;
    row = 21'h000000;
    acnt = 3'h0;
    drv = 1'b0;
    bsy0 = 0;
    bsy1 = 0;
    prog_cnt = 0;
  end
  always @(posedge we_n)
    if (act && cle)
    begin
      cmd <= bus_o;
      acnt <= 0;
      if (bus_o == 8'h30 || (bus_o == 8'h10 && wp_n))
      begin
        if (d)
          bsy1 <= 40;
        else
          bsy0 <= 40;
      end
      if (bus_o == 8'h10 && wp_n)
        prog_cnt <= prog_cnt + 1;
    end
    else if (act && ale)
    begin
      case (acnt)
        0: col[7:0] <= bus_o;
        1: col[13:8] <= bus_o[5:0];
        2: row[7:0] <= bus_o;
        3: row[15:8] <= bus_o;
        default: row[20:16] <= bus_o[4:0];
      endcase
      acnt <= acnt + 1;
    end
  always @(posedge mclk)
  begin
    bsy0 <= (bsy0 > 0) ? bsy0 - 1 : 0;
    bsy1 <= (bsy1 > 0) ? bsy1 - 1 : 0;
  end
  assign rb = {bsy1 == 0, bsy0 == 0};
  always @(negedge rd_strb_n)
    if (act)
    begin
      dout <= col[7:0] ^ 8'h5a;
      col <= col + 1;
      drv <= 1'b1;
    end
  always @(posedge rd_strb_n)
    drv <= 1'b0;
  assign io_in = bus_oe ? bus_o : (drv ? dout : ~dout);
endmodule // nand_die_model

// [tb/tb_top.sv]
// Self-checking bench for the NAND port controller
`timescale 1ns/10ps
module tb_top;
  reg mclk, rstn, req_valid, req_die, req_last, req_wait, wr_guard, rd_ready;
  reg [1:0] req_op;
  reg [7:0] req_data;
  reg [13:0] req_col, c;
  reg [20:0] req_row, r;
  reg [15:0] lf;
  wire req_ready_ff, rd_valid, busy_ff, timeout_ff, cmd_latch_ff, addr_latch_ff;
  wire input_strobe_n_ff, output_strobe_n_ff, write_guard_n_ff, io_oe_ff;
  wire [7:0] rd_data, io_in, io_out_ff, page_ff;
  wire [12:0] blk_ff;
  wire [1:0] sel_n_ff, idle_flag_open_drain;
  integer miscompares, cmp_count, i, n, p0, g;
  nand_port_ctrl DUT (.mclk(mclk), .rstn(rstn), .req_valid(req_valid),
    .req_ready_ff(req_ready_ff), .req_op(req_op), .req_data(req_data), .req_die(req_die),
    .req_last(req_last), .req_wait(req_wait), .req_col(req_col), .req_row(req_row),
    .wr_guard(wr_guard), .rd_data_ff(rd_data), .rd_valid_ff(rd_valid), .rd_ready(rd_ready),
    .busy_ff(busy_ff), .timeout_ff(timeout_ff), .blk_ff(blk_ff), .page_ff(page_ff),
    .cmd_latch_ff(cmd_latch_ff), .addr_latch_ff(addr_latch_ff),
    .input_strobe_n_ff(input_strobe_n_ff), .output_strobe_n_ff(output_strobe_n_ff),
    .sel_n_ff(sel_n_ff), .write_guard_n_ff(write_guard_n_ff), .io_in(io_in),
    .io_out_ff(io_out_ff), .io_oe_ff(io_oe_ff), .idle_flag_open_drain(idle_flag_open_drain));
  nand_die_model u_die (.mclk(mclk), .cle(cmd_latch_ff), .ale(addr_latch_ff),
    .we_n(input_strobe_n_ff), .rd_strb_n(output_strobe_n_ff), .ce_n(sel_n_ff),
    .wp_n(write_guard_n_ff), .bus_o(io_out_ff), .bus_oe(io_oe_ff), .io_in(io_in),
    .rb(idle_flag_open_drain));
  function [15:0] nx(input [15:0] x);
    nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function [7:0] exp_rd(input [13:0] a);
    exp_rd = a[7:0] ^ 8'h5a;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task rq(input [1:0] op, input [7:0] dt, input die, input last, input w);
    begin
      req_op <= op;
      req_data <= dt;
      req_die <= die;
      req_last <= last;
      req_wait <= w;
      req_valid <= 1'b1;
      n = 0;
      @(posedge mclk);
      while (req_ready_ff !== 1'b1 && n < 3000)
      begin
        n = n + 1;
        @(posedge mclk);
      end
      req_valid <= 1'b0;
      @(posedge mclk);
      while (busy_ff !== 1'b0 && n < 3000)
      begin
        n = n + 1;
        @(posedge mclk);
      end
      if (n >= 3000)
      begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: request never finished", $time);
        close_out;
      end
    end
  endtask
  initial
  begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_data = 8'h00;
    req_die = 1'b0;
    req_last = 1'b0;
    req_wait = 1'b0;
    req_col = 14'h0000;
    req_row = 21'h000000;
    wr_guard = 1'b0;
    rd_ready = 1'b0;
    lf = 16'h71ec;
    miscompares = 0;
    cmp_count = 0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk(sel_n_ff, 2'b11);
    chk(io_oe_ff, 0);
    wr_guard <= 1'b1;
    for (p0 = 0; p0 < 4; p0 = p0 + 1)
    begin
      lf = nx(lf);
      c = lf[13:0];
      lf = nx(lf);
      r = {lf[4:0], nx(lf)};
      if (p0 == 0)
      begin
        c = 14'h3ffc;
        r = 21'h1fffff;
      end
      req_col <= c;
      req_row <= r;
      rq(2'h0, 8'h00, p0[0], 1'b0, 1'b0);
      rq(2'h1, 8'h00, p0[0], 1'b0, 1'b0);
      chk(blk_ff, r[20:8]);
      chk(page_ff, r[7:0]);
      chk(u_die.col, c);
      chk(u_die.row, r);
      rq(2'h0, 8'h30, p0[0], 1'b0, 1'b1);
      chk(idle_flag_open_drain, 2'b11);
      chk(timeout_ff, 0);
      for (i = 0; i < 8; i = i + 1)
        rq(2'h3, 8'h00, p0[0], i == 7, 1'b0);
      chk(rd_valid, 1);
      rd_ready <= 1'b1;
      i = 0;
      for (n = 0; i < 8 && n < 40; n = n + 1)
      begin
        @(posedge mclk);
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
        begin
          chk(rd_data, exp_rd(c + i));
          i = i + 1;
        end
      end
      chk(i, 8);
      rd_ready <= 1'b0;
      $display("read test %0d done", p0);
    end
    for (g = 1; g >= 0; g = g - 1)
    begin
      wr_guard <= g[0];
      repeat (12) @(posedge mclk);
      p0 = u_die.prog_cnt;
      rq(2'h0, 8'h80, 1'b1, 1'b0, 1'b0);
      rq(2'h1, 8'h00, 1'b1, 1'b0, 1'b0);
      rq(2'h2, lf[7:0], 1'b1, 1'b0, 1'b0);
      rq(2'h0, 8'h10, 1'b1, 1'b1, 1'b1);
      chk(u_die.prog_cnt, p0 + g);
      chk(idle_flag_open_drain, 2'b11);
      $display("program test guard %0d done", g);
    end
    close_out;
  end
endmodule // tb_top
